// *** hdl/steer_defs.svh ***
// Purpose: Offsets, field positions and reset values of the steering unit
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef STEER_DEFS_SVH
`define STEER_DEFS_SVH
`define CTRL_OFFSET 4'h0
`define DUTY_HIGH_OFFSET 4'h4
`define STATUS_OFFSET 4'h8
`define CTRL_RESET 8'h00
`define DUTY_HIGH_RESET 8'h00
`define STEER_MSB 7
`define STEER_LSB 6
`define DUTY_LOW_MSB 5
`define DUTY_LOW_LSB 4
`define MODE_MSB 3
`define MODE_LSB 0
`define MODE_OFF 4'h0
`define MODE_RESERVED 4'h1
`define MODE_PWM_TOP 2'h3
`endif

// *** hdl/steer_pkg.sv ***
// Purpose: Types shared by the steering unit
// Assumes: Nothing
// Notes: Steering codes of the output configuration field
package steer_pkg;
  typedef enum logic [1:0] {
    STEER_SINGLE = 2'h0,
    STEER_FULL_FWD = 2'h1,
    STEER_HALF = 2'h2,
    STEER_FULL_REV = 2'h3
  } steer_type;
endpackage

// *** hdl/pin_steer.sv ***
// Purpose: One output pin steering cell
// Assumes: Select codes from the control block
// Notes: Chooses port value, modulated, active or inactive level
`timescale 1ns/1ns
module pin_steer (
  input wire logic [1:0] sel,
  input wire logic mod_in,
  input wire logic port_in,
  output logic pin_out,
  output logic owned
);
  // 0 port, 1 modulated, 2 active, 3 inactive
  assign pin_out = (sel == 2'h0) ? port_in : (sel == 2'h1) ? mod_in : (sel == 2'h2);
  assign owned = (sel != 2'h0);
endmodule

// *** hdl/enhanced_pwm_output_steering.sv ***
// Purpose: Control register and PWM output steering of the enhanced compare unit
// Assumes: Classic Wishbone slave, one-cycle ack, timebase and dead band outside
// Notes: Pin outputs are registered
`timescale 1ns/1ns
`include "steer_defs.svh"

// Notes on behaviour
// - Steering field bits 7-6, PWM only
// - Non-PWM modes except 0000: A capture pin, others port
// - Steer 00: modulate A, release B C D
// - Steer 01: D modulated, A active, B C inactive
// - Steer 10: A B complementary with dead band
// - Steer 11: B modulated, C active, A D inactive
// - Bits 5-4 give duty low two bits
// - Mode bits 3-0; 0000 resets unit idle
module enhanced_pwm_output_steering
  import steer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic pwm_raw,
  input wire logic pwm_dead_a,
  input wire logic pwm_dead_b,
  input wire logic [3:0] port_data,
  output logic [9:0] duty_value,
  output logic pwm_enable,
  output logic unit_reset,
  output logic capture_on_a,
  output logic pwm_out_a,
  output logic pwm_out_b,
  output logic pwm_out_c,
  output logic pwm_out_d,
  output logic [3:0] pin_owned
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus decode
  logic [7:0] ccp_unit_control_r;
  logic [7:0] duty_high_byte_r;
  logic ack_r;
  logic [31:0] rdata_r;
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [3:0] pins_r;

  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
  wire sel_ctrl = (wb_adr_i == `CTRL_OFFSET);
  wire sel_duty = (wb_adr_i == `DUTY_HIGH_OFFSET);
  wire sel_stat = (wb_adr_i == `STATUS_OFFSET);

  // Control register fields
  wire [1:0] output_steer_config = ccp_unit_control_r[`STEER_MSB:`STEER_LSB];
  wire [1:0] duty_low_bits = ccp_unit_control_r[`DUTY_LOW_MSB:`DUTY_LOW_LSB];
  wire [3:0] unit_mode_select = ccp_unit_control_r[`MODE_MSB:`MODE_LSB];
  wire mode_off = (unit_mode_select == `MODE_OFF);
  wire pwm_mode = (unit_mode_select[3:2] == `MODE_PWM_TOP);
  wire steer_type st = steer_type'(output_steer_config);

  // Read data mux, unmapped reads as zero
  wire [31:0] rd_mux = sel_ctrl ? {24'h00_0000, ccp_unit_control_r} :
                       sel_duty ? {24'h00_0000, duty_high_byte_r} :
                       sel_stat ? {26'h000_0000, pwm_mode, mode_off, pins_r} : 32'h0000_0000;

  // Register writes; reserved mode 0001 stored as written, software must avoid it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ccp_unit_control_r <= `CTRL_RESET;
      duty_high_byte_r <= `DUTY_HIGH_RESET;
    end else begin
      if (wr_lane0 && sel_ctrl) begin
        ccp_unit_control_r <= wb_dat_i[7:0];
      end
      if (wr_lane0 && sel_duty) begin
        duty_high_byte_r <= wb_dat_i[7:0];
      end
    end
  end

  // One-cycle ack for every access, mapped or not
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      rdata_r <= bus_req ? rd_mux : rdata_r;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Mode outputs to the timebase and comparator
  assign duty_value = pwm_mode ? {duty_high_byte_r, duty_low_bits} : 10'h000;
  assign pwm_enable = pwm_mode;
  assign unit_reset = mode_off;
  assign capture_on_a = ~pwm_mode & ~mode_off;

  ////////////////////////////////////////////////////////////////////////////
  // Steering selection: 0 port, 1 modulated, 2 active, 3 inactive
  logic [1:0] sel_a;
  logic [1:0] sel_b;
  logic [1:0] sel_c;
  logic [1:0] sel_d;
  logic mod_a;
  logic mod_b;

  // Per-mode pin selection; any pin not listed stays under port control
  always_comb begin
    sel_a = 2'h0;
    sel_b = 2'h0;
    sel_c = 2'h0;
    sel_d = 2'h0;
    mod_a = pwm_raw;
    mod_b = pwm_raw;
    if (pwm_mode) begin
      case (st)
        STEER_SINGLE: begin
          sel_a = 2'h1;
        end
        STEER_FULL_FWD: begin
          sel_a = 2'h2;
          sel_b = 2'h3;
          sel_c = 2'h3;
          sel_d = 2'h1;
        end
        STEER_HALF: begin
          sel_a = 2'h1;
          sel_b = 2'h1;
          mod_a = pwm_dead_a;
          mod_b = pwm_dead_b;
        end
        STEER_FULL_REV: begin
          sel_a = 2'h3;
          sel_b = 2'h1;
          sel_c = 2'h2;
          sel_d = 2'h3;
        end
        default: begin
          sel_a = 2'h0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Port inputs cross from outside, two flip-flops each
  logic [3:0] port_s1_r;
  logic [3:0] port_s2_r;
  wire [3:0] pin_nxt;
  wire [3:0] own_nxt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      port_s1_r <= 4'h0;
      port_s2_r <= 4'h0;
    end else begin
      port_s1_r <= port_data;
      port_s2_r <= port_s1_r;
    end
  end

  // One steering cell per pin; A and B may take the dead-band pair
  pin_steer u_a (
    .sel(sel_a),
    .mod_in(mod_a),
    .port_in(port_s2_r[0]),
    .pin_out(pin_nxt[0]),
    .owned(own_nxt[0])
  );
  pin_steer u_b (
    .sel(sel_b),
    .mod_in(mod_b),
    .port_in(port_s2_r[1]),
    .pin_out(pin_nxt[1]),
    .owned(own_nxt[1])
  );
  // C and D only ever modulate with the raw PWM
  pin_steer u_c (
    .sel(sel_c),
    .mod_in(pwm_raw),
    .port_in(port_s2_r[2]),
    .pin_out(pin_nxt[2]),
    .owned(own_nxt[2])
  );
  pin_steer u_d (
    .sel(sel_d),
    .mod_in(pwm_raw),
    .port_in(port_s2_r[3]),
    .pin_out(pin_nxt[3]),
    .owned(own_nxt[3])
  );

  // Registered pin drive and ownership
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pins_r <= 4'h0;
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      pins_r <= pin_nxt;
      sync1_r <= own_nxt[1:0];
      sync2_r <= own_nxt[3:2];
    end
  end

  assign pwm_out_a = pins_r[0];
  assign pwm_out_b = pins_r[1];
  assign pwm_out_c = pins_r[2];
  assign pwm_out_d = pins_r[3];
  assign pin_owned = {sync2_r, sync1_r};
endmodule

// *** verif/bridge_stage.sv ***
// Purpose: Bridge power stage on the far side of the pins
// Assumes: Legs A-B and C-D, gates active high
// Notes: Flags a leg with both switches on
`timescale 1ns/1ns
module bridge_stage (
  input wire logic gate_a,
  input wire logic gate_b,
  input wire logic gate_c,
  input wire logic gate_d,
  output logic shoot
);
  // Shoot-through on either leg
  assign shoot = (gate_a & gate_b) | (gate_c & gate_d);
endmodule

// *** verif/steer_sva.sv ***
// Purpose: Port assertions of the steering unit
// Assumes: Pins registered one cycle after selection
// Notes: Bound to the top module
`timescale 1ns/1ns
module steer_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pwm_raw,
  input wire logic pwm_dead_a,
  input wire logic pwm_dead_b,
  input wire logic [9:0] duty_value,
  input wire logic pwm_enable,
  input wire logic unit_reset,
  input wire logic capture_on_a,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  input wire logic pwm_out_c,
  input wire logic pwm_out_d,
  input wire logic [3:0] pin_owned
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // Mode decode and pin ownership
  duty_idle_a: assert property (!pwm_enable |-> duty_value == 10'h000)
    else $error("duty not zero");
  off_idle_a: assert property (unit_reset |-> !pwm_enable && !capture_on_a)
    else $error("off mode not idle");
  pwm_excl_a: assert property (pwm_enable |-> !capture_on_a)
    else $error("pwm and capture both");
  cap_port_a: assert property ($past(capture_on_a) |-> pin_owned[3:1] == 3'h0)
    else $error("capture owns pins");
  off_port_a: assert property ($past(unit_reset) |-> pin_owned == 4'h0)
    else $error("off mode owns pins");
  pwm_own_a: assert property ($past(pwm_enable) |-> pin_owned[0])
    else $error("pwm lost pin a");
  single_out_a: assert property ($past(pwm_enable) && pin_owned == 4'h1 |-> pwm_out_a == $past(pwm_raw))
    else $error("single output wrong");
  half_bridge_a: assert property (pin_owned == 4'h3 |-> {pwm_out_a, pwm_out_b} == $past({pwm_dead_a, pwm_dead_b}))
    else $error("half bridge wrong");
  full_bridge_a: assert property (pin_owned == 4'hF |->
    (pwm_out_a ? !pwm_out_b && !pwm_out_c && pwm_out_d == $past(pwm_raw) :
    pwm_out_c && !pwm_out_d && pwm_out_b == $past(pwm_raw)))
    else $error("full bridge wrong");
endmodule
bind enhanced_pwm_output_steering steer_sva i_sva (.mclk(mclk), .rst(rst), .pwm_raw(pwm_raw),
  .pwm_dead_a(pwm_dead_a), .pwm_dead_b(pwm_dead_b), .duty_value(duty_value), .pwm_enable(pwm_enable),
  .unit_reset(unit_reset), .capture_on_a(capture_on_a), .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
  .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d), .pin_owned(pin_owned));

// *** verif/enhanced_pwm_output_steering_bench.sv ***
// Purpose: Self-checking bench of the steering unit
// Assumes: Dead pair 1/0, port pins 0110
// Notes: Table of control values, then reset cases
`timescale 1ns/1ns
module enhanced_pwm_output_steering_bench;
  typedef struct packed {logic [7:0] ctl; logic raw; logic [3:0] pins; logic [3:0] own;} row_type;
  logic mclk = 0, rst = 1, cyc = 0, stb = 0, we = 0, raw = 0;
  logic [3:0] adr = 4'h0, sel = 4'hF, port = 4'h6, own;
  logic [31:0] dat = 32'h0, q, dat_o;
  logic ack, pen, ures, cap, a, b, c, d, shoot;
  logic [9:0] duty;
  int checks = 0, miscompares = 0;
  // Mode 0001 is never written
  row_type rows [9] = '{'{8'h1C, 1, 4'h7, 4'h1}, '{8'h6C, 1, 4'h9, 4'hF}, '{8'h6D, 0, 4'h1, 4'hF},
    '{8'hBC, 1, 4'h5, 4'h3}, '{8'hCE, 1, 4'h6, 4'hF}, '{8'hCF, 0, 4'h4, 4'hF},
    '{8'h34, 1, 4'h6, 4'h0}, '{8'hFB, 1, 4'h6, 4'h0}, '{8'hC0, 1, 4'h6, 4'h0}};
  enhanced_pwm_output_steering i_dut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pwm_raw(raw),
    .pwm_dead_a(1'b1), .pwm_dead_b(1'b0), .port_data(port), .duty_value(duty), .pwm_enable(pen),
    .unit_reset(ures), .capture_on_a(cap), .pwm_out_a(a), .pwm_out_b(b), .pwm_out_c(c), .pwm_out_d(d),
    .pin_owned(own));
  bridge_stage i_stage (.gate_a(a), .gate_b(b), .gate_c(c), .gate_d(d), .shoot(shoot));
  ////////////////////////////////////////////////////////////////
  // Clock and watchdog
  always #5 mclk = ~mclk;
  initial begin
    #20000;
    miscompares++;
    test_done();
  end
  // Classic single bus cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] ad, input logic [7:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    dat <= {24'h0, wd};
    do @(posedge mclk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 0;
    stb <= 0;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic test_done;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Table pass, then unmapped read and reset in mid-run
  initial begin
    repeat (16) @(posedge mclk);
    rst <= 0;
    wb(1, 4'h4, 8'hA5, q);
    wb(0, 4'h4, 8'h0, q);
    chk("duty_high", q, 32'h0000_00A5);
    for (int i = 0; i < 9; i++) begin
      logic exp_pwm;
      logic exp_off;
      exp_pwm = rows[i].ctl[3:2] == 2'h3;
      exp_off = rows[i].ctl[3:0] == 4'h0;
      raw <= rows[i].raw;
      wb(1, 4'h0, rows[i].ctl, q);
      repeat (2) @(posedge mclk);
      #1;
      chk("pins", {d, c, b, a}, rows[i].pins);
      chk("own", own, rows[i].own);
      chk("mode", {cap, pen, ures}, {!exp_pwm && !exp_off, exp_pwm, exp_off});
      chk("duty", duty, rows[i].ctl[3:2] == 2'h3 ? {8'hA5, rows[i].ctl[5:4]} : 10'h0);
      if (rows[i].own == 4'hF) chk("shoot", shoot, 0);
      wb(0, 4'h0, 8'h0, q);
      chk("ctl", q, rows[i].ctl);
      wb(0, 4'h8, 8'h0, q);
      chk("status", q, {26'h000_0000, exp_pwm, exp_off, rows[i].pins});
    end
    wb(0, 4'hC, 8'h0, q);
    chk("unmapped", q, 0);
    // Off mode: pins follow a non-symmetric port pattern
    port <= 4'hC;
    repeat (4) @(posedge mclk);
    #1;
    chk("port", {d, c, b, a}, 4'hC);
    // Write with lane 0 disabled must leave the control register alone
    @(posedge mclk);
    sel <= 4'hE;
    wb(1, 4'h0, 8'hCC, q);
    sel <= 4'hF;
    wb(0, 4'h0, 8'h0, q);
    chk("sel_skip", q, 32'h0000_00C0);
    wb(1, 4'h0, 8'hCC, q);
    rst <= 1;
    repeat (2) @(posedge mclk);
    chk("off", {ures, pen, cap, own, d, c, b, a}, 11'h400);
    rst <= 0;
    wb(0, 4'h0, 8'h0, q);
    chk("ctl0", q, 0);
    test_done();
  end
endmodule
